// [src/ivp_cmd_unit.sv]
// Command interpreter slice: handler vectors, handler return, extension opcodes, position-reached events.
// Assumes a frame decoder delivering one command per strobe and a frame encoder taking replies.
// How it works
// - Opcode 37 stores value as type's vector.
// - Redefining a vector overwrites the old address.
// - Opcode 38 restores saved context, resumes program.
// - Direct vector/return answers status 100.
// - Opcodes 64..71 reply 100, user value.
// - Opcode 138 replies now, notifies later.
// - Value field is motor selection bit mask.
// - Type 0 arms only the next absolute move.
// - Type 1 arms every following absolute move.
// - Notification: status 128, opcode 138, mask.
`timescale 1ns/1ps
`include "ivp_map.svh"
module ivp_cmd_unit
  import ivp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire ivp_cmd_t cmd,
  input wire logic cmd_direct,
  input wire logic [31:0] ext_value,
  input wire logic [`IVP_NUM_MOTORS-1:0] move_abs_start,
  input wire logic [`IVP_NUM_MOTORS-1:0] target_reached,
  input wire logic irq_take,
  input wire logic [3:0] irq_num,
  input wire ivp_ctx_t live_ctx,
  output logic reply_valid,
  output ivp_reply_t reply,
  output logic ctx_load,
  output ivp_ctx_t ctx_out,
  output logic [15:0] jump_pc,
  output logic in_handler,
  output logic ext_strobe
);
  localparam int NV = `IVP_NUM_DEFINE_HANDLER_ENTRY;
  localparam int NM = `IVP_NUM_MOTORS;

  // Vector table and saved context.
  logic [15:0] define_handler_entry_q [NV];
  logic [15:0] define_handler_entry_d [NV];
  ivp_ctx_t saved_q, saved_d;
  ivp_state_t state_q, state_d;
  logic ctx_load_q, ctx_load_d;
  ivp_ctx_t ctx_out_q, ctx_out_d;
  logic [15:0] jump_q, jump_d;
  logic ext_q, ext_d;

  wire logic is_def = cmd_valid && cmd.opcode == `IVP_OP_DEF_ENTRY;
  wire logic is_ret = cmd_valid && cmd.opcode == `IVP_OP_HANDLER_RET;
  wire logic is_ext = cmd_valid && cmd.opcode >= `IVP_OP_EXT_FIRST && cmd.opcode <= `IVP_OP_EXT_LAST;
  wire logic is_pos = cmd_valid && cmd.opcode == `IVP_OP_POS_EVENT;

  // Vector writes; the bank field is ignored and a later write simply replaces the entry.
  genvar gv;
  generate
    for (gv = 0; gv < NV; gv++) begin : g_define_handler_entry
      always_comb begin
        define_handler_entry_d[gv] = define_handler_entry_q[gv];
        if (is_def && cmd.ctype == 8'(gv)) begin
          define_handler_entry_d[gv] = cmd.value[15:0];
        end
      end
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          define_handler_entry_q[gv] <= 16'h0000;
        end else begin
          define_handler_entry_q[gv] <= define_handler_entry_d[gv];
        end
      end
    end
  endgenerate

  // Context save on interrupt entry, restore on handler return.
  // A direct return is answered but restores nothing, nor does one outside a handler, so a stray one cannot corrupt flow.
  always_comb begin
    state_d = state_q;
    saved_d = saved_q;
    ctx_load_d = 1'b0;
    ctx_out_d = ctx_out_q;
    jump_d = jump_q;
    unique case (state_q)
      IVP_RUN: begin
        if (irq_take) begin
          saved_d = live_ctx;
          jump_d = define_handler_entry_q[irq_num];
          state_d = IVP_IN_HANDLER;
        end
      end
      IVP_IN_HANDLER: begin
        if (is_ret && !cmd_direct) begin
          ctx_out_d = saved_q;
          jump_d = saved_q.pc;
          ctx_load_d = 1'b1;
          state_d = IVP_HOLD;
        end
      end
      IVP_HOLD: begin
        state_d = IVP_RUN;
      end
      default: begin
        state_d = IVP_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IVP_RUN;
      saved_q <= '0;
      ctx_load_q <= 1'b0;
      ctx_out_q <= '0;
      jump_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      saved_q <= saved_d;
      ctx_load_q <= ctx_load_d;
      ctx_out_q <= ctx_out_d;
      jump_q <= jump_d;
    end
  end

  // Position-reached arming: one-shot masks are consumed by the next absolute move, persistent ones stay.
  logic [NM-1:0] once_q, once_d, pers_q, pers_d, watch_q, watch_d, hit;
  always_comb begin
    once_d = once_q;
    pers_d = pers_q;
    watch_d = watch_q;
    if (|move_abs_start) begin
      watch_d = watch_q | (move_abs_start & (once_q | pers_q));
      once_d = once_q & ~move_abs_start;
    end
    hit = watch_q & target_reached;
    watch_d = watch_d & ~hit;
    if (is_pos && cmd_direct) begin
      if (cmd.ctype == `IVP_EVT_ONCE) begin
        once_d = cmd.value[NM-1:0];
      end else if (cmd.ctype == `IVP_EVT_ALWAYS) begin
        pers_d = cmd.value[NM-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      once_q <= '0;
      pers_q <= '0;
      watch_q <= '0;
    end else begin
      once_q <= once_d;
      pers_q <= pers_d;
      watch_q <= watch_d;
    end
  end

  // Reply path; an immediate command reply takes priority and a pending event waits one frame.
  logic [NM-1:0] pend_q, pend_d;
  logic rv_q, rv_d;
  ivp_reply_t rep_q, rep_d;
  always_comb begin
    pend_d = pend_q | hit;
    rv_d = 1'b0;
    rep_d = rep_q;
    ext_d = 1'b0;
    if (cmd_valid && cmd_direct) begin
      rv_d = 1'b1;
      rep_d.opcode = cmd.opcode;
      rep_d.status = `IVP_ST_OK;
      rep_d.value = `IVP_RST_ZERO32;
      if (is_ext) begin
        rep_d.value = ext_value;
        ext_d = 1'b1;
      end else if (is_pos) begin
        rep_d.value = {24'h000000, 8'(cmd.value[NM-1:0])};
      end else if (!is_def && !is_ret) begin
        rep_d.status = `IVP_ST_BAD_CMD;
      end
    end else if (|pend_q) begin
      rv_d = 1'b1;
      rep_d.status = `IVP_ST_EVENT;
      rep_d.opcode = `IVP_OP_POS_EVENT;
      rep_d.value = {24'h000000, 8'(pend_q)};
      pend_d = hit;
    end else if (cmd_valid && is_ext) begin
      ext_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= '0;
      rv_q <= 1'b0;
      rep_q <= '0;
      ext_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      rv_q <= rv_d;
      rep_q <= rep_d;
      ext_q <= ext_d;
    end
  end

  assign reply_valid = rv_q;
  assign reply = rep_q;
  assign ctx_load = ctx_load_q;
  assign ctx_out = ctx_out_q;
  assign jump_pc = jump_q;
  // One-hot state, so the handler bit is itself a flop and the output needs no decode.
  assign in_handler = state_q[1];
  assign ext_strobe = ext_q;

  // Checks next to the logic.
  property p_def_store;
    @(posedge clk_sys) disable iff (!reset_n)
      is_def && cmd.ctype < 8'(NV) |=> define_handler_entry_q[$past(cmd.ctype[3:0])] == $past(cmd.value[15:0]);
  endproperty
  a_def_store: assert property (p_def_store) else $error("Vector not stored.");

  property p_direct_ok;
    @(posedge clk_sys) disable iff (!reset_n)
      cmd_valid && cmd_direct && (is_def || is_ret) |=> reply_valid && reply.status == `IVP_ST_OK;
  endproperty
  a_direct_ok: assert property (p_direct_ok) else $error("Direct vector or return not answered OK.");

  property p_ext_reply;
    @(posedge clk_sys) disable iff (!reset_n)
      is_ext && cmd_direct |=> reply.status == `IVP_ST_OK && reply.value == $past(ext_value);
  endproperty
  a_ext_reply: assert property (p_ext_reply) else $error("Extension reply wrong.");

  property p_pos_now;
    @(posedge clk_sys) disable iff (!reset_n)
      is_pos && cmd_direct |=> reply_valid && reply.opcode == `IVP_OP_POS_EVENT && reply.status == `IVP_ST_OK;
  endproperty
  a_pos_now: assert property (p_pos_now) else $error("Position request not answered at once.");

  property p_event_fmt;
    @(posedge clk_sys) disable iff (!reset_n)
      reply_valid && reply.status == `IVP_ST_EVENT |-> reply.opcode == `IVP_OP_POS_EVENT && reply.value[31:8] == 24'h0;
  endproperty
  a_event_fmt: assert property (p_event_fmt) else $error("Notification format wrong.");

  property p_hit_reported;
    @(posedge clk_sys) disable iff (!reset_n)
      |hit |-> ##[1:3] (reply_valid && reply.status == `IVP_ST_EVENT);
  endproperty
  a_hit_reported: assert property (p_hit_reported) else $error("Reached motor not reported.");

  property p_once_clears;
    @(posedge clk_sys) disable iff (!reset_n)
      (|(move_abs_start & once_q)) && !(is_pos && cmd_direct) |=> (once_q & $past(move_abs_start)) == '0;
  endproperty
  a_once_clears: assert property (p_once_clears) else $error("One-shot arming not consumed.");

  property p_pers_keeps;
    @(posedge clk_sys) disable iff (!reset_n)
      |move_abs_start && !(is_pos && cmd_direct) |=> pers_q == $past(pers_q);
  endproperty
  a_pers_keeps: assert property (p_pers_keeps) else $error("Persistent arming lost.");

  property p_irq_entry;
    @(posedge clk_sys) disable iff (!reset_n)
      state_q == IVP_RUN && irq_take |=> in_handler && saved_q == $past(live_ctx) && jump_pc == $past(define_handler_entry_q[irq_num]);
  endproperty
  a_irq_entry: assert property (p_irq_entry) else $error("Interrupt entry wrong.");

  property p_ret_restore;
    @(posedge clk_sys) disable iff (!reset_n)
      in_handler && is_ret && !cmd_direct |=> ctx_load && ctx_out == $past(saved_q) ##1 !ctx_load;
  endproperty
  a_ret_restore: assert property (p_ret_restore) else $error("Context not restored.");
endmodule

// [src/ivp_map.svh]
// Constants for the vector and position-event command slice.
// Assumes inclusion by the package and the design module only.
`ifndef IVP_MAP_SVH
`define IVP_MAP_SVH
`define IVP_OP_DEF_ENTRY 8'h25
`define IVP_OP_HANDLER_RET 8'h26
`define IVP_OP_EXT_FIRST 8'h40
`define IVP_OP_EXT_LAST 8'h47
`define IVP_OP_POS_EVENT 8'h8a
`define IVP_ST_OK 8'h64
`define IVP_ST_EVENT 8'h80
`define IVP_ST_BAD_CMD 8'h02
`define IVP_EVT_ONCE 8'h00
`define IVP_EVT_ALWAYS 8'h01
`define IVP_NUM_MOTORS 6
`define IVP_NUM_DEFINE_HANDLER_ENTRY 16
`define IVP_RST_ZERO32 32'h0000_0000
`endif

// [src/ivp_pkg.sv]
// Types shared by the vector and position-event command slice.
// Assumes the constants header is available on the include path.
`include "ivp_map.svh"
package ivp_pkg;
  // One binary command as the frame decoder hands it over.
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] ctype;
    logic [7:0] bank;
    logic [31:0] value;
  } ivp_cmd_t;
  // One reply frame body handed to the frame encoder.
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
  } ivp_reply_t;
  // Program context saved at interrupt entry.
  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0] flags;
    logic [15:0] pc;
  } ivp_ctx_t;
  // Interpreter state.
  typedef enum logic [2:0] {
    IVP_RUN = 3'b001,
    IVP_IN_HANDLER = 3'b010,
    IVP_HOLD = 3'b100
  } ivp_state_t;
endpackage

// [dv/ivp_host_model.sv]
// Host-side model: counts every reply frame the block hands to the encoder.
// Assumes reply_valid is a registered one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module ivp_host_model
  import ivp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reply_valid,
  input wire ivp_reply_t reply,
  output logic [7:0] seen_count
);
  // The host never stalls, so a reply is taken on the cycle it stands.
  // Only the count is kept, which lets the bench see replies that should not exist.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seen_count <= 8'h00;
    end else if (reply_valid) begin
      seen_count <= seen_count + 8'h01;
    end
  end
endmodule

// [dv/tb.sv]
// Self-checking bench for the vector and position-event command slice.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps
module tb;
  import ivp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_direct = 1'b0;
  logic irq_take = 1'b0;
  ivp_cmd_t cmd = '0;
  logic [31:0] ext_value = 32'h0000_0000;
  logic [5:0] move_abs_start = 6'h00;
  logic [5:0] target_reached = 6'h00;
  logic [3:0] irq_num = 4'h0;
  ivp_ctx_t live_ctx = '0;
  logic reply_valid, ctx_load, in_handler, ext_strobe;
  ivp_reply_t reply;
  ivp_ctx_t ctx_out;
  logic [15:0] jump_pc;
  logic [7:0] seen_count;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  ivp_cmd_unit u_ivp_cmd_unit (.clk_sys, .reset_n, .cmd_valid, .cmd, .cmd_direct, .ext_value,
    .move_abs_start, .target_reached, .irq_take, .irq_num, .live_ctx, .reply_valid, .reply,
    .ctx_load, .ctx_out, .jump_pc, .in_handler, .ext_strobe);
  ivp_host_model u_ivp_host_model (.clk_sys, .reset_n, .reply_valid, .reply, .seen_count);

  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Wide enough for the full restored context plus its strobe and jump address.
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command, taken at the second edge; returns just after that edge so the reply can be looked at.
  task automatic send(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] val, input logic dir);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{op, ty, 8'h5a, val}; // A non-zero bank shows that the field is ignored.
    cmd_direct <= dir;
    ext_value <= ~val;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
  endtask

  // A motor starts an absolute move and reaches its target one cycle later.
  task automatic move(input logic [5:0] m);
    @(posedge clk_sys);
    move_abs_start <= m;
    @(posedge clk_sys);
    move_abs_start <= 6'h00;
    target_reached <= m;
    @(posedge clk_sys);
    target_reached <= 6'h00;
  endtask

  task automatic get_event(input logic [31:0] mask);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4 && !hit; i++) begin
      @(posedge clk_sys);
      #1;
      hit = (reply_valid === 1'b1);
    end
    chk(hit, 1'b1);
    chk({reply.status, reply.opcode, reply.value}, {8'h80, 8'h8a, mask});
  endtask

  task automatic t_direct();
    logic [7:0] ops [3] = '{8'h25, 8'h26, 8'h10};
    logic [7:0] st [3] = '{8'h64, 8'h64, 8'h02};
    for (int i = 0; i < 3; i++) begin
      send(ops[i], 8'h00, 32'h0000_0000, 1'b1);
      chk({reply_valid, reply.status}, {1'b1, st[i]});
    end
    for (int i = 0; i < 8; i++) begin
      send(8'(8'h40 + i), 8'(i), 32'(i), 1'b1);
      chk({reply_valid, ext_strobe, reply.status, reply.value}, {2'b11, 8'h64, ~32'(i)});
    end
  endtask

  task automatic t_vectors();
    logic [7:0] n;
    // The last direct reply is counted at the edge after it stands, so let that edge pass first.
    @(posedge clk_sys);
    #1;
    n = seen_count;
    send(8'h25, 8'h03, 32'h0000_1234, 1'b0); // program mode; a direct one stores as well
    send(8'h25, 8'h03, 32'h0000_0055, 1'b0);
    @(posedge clk_sys);
    live_ctx <= '{32'h1111_2222, 32'h3333_4444, 8'h5a, 16'h0777};
    irq_num <= 4'h3;
    irq_take <= 1'b1;
    @(posedge clk_sys);
    irq_take <= 1'b0;
    live_ctx <= '0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({in_handler, jump_pc}, {1'b1, 16'h0055});
    send(8'h26, 8'hff, 32'h0000_0000, 1'b0); // the handler ends with a return
    chk({ctx_load, ctx_out, jump_pc}, {1'b1, 32'h1111_2222, 32'h3333_4444, 8'h5a, 16'h0777, 16'h0777});
    @(posedge clk_sys);
    #1;
    chk(in_handler, 1'b0);
    chk(seen_count, n);
  endtask

  task automatic t_event();
    logic [7:0] n;
    send(8'h8a, 8'h01, 32'h0000_0005, 1'b1); // direct mode only
    chk({reply_valid, reply.status, reply.value}, {1'b1, 8'h64, 32'h0000_0005});
    repeat (2) begin
      move(6'h01);
      get_event(32'h0000_0001);
    end
    move(6'h04);
    get_event(32'h0000_0004);
    send(8'h8a, 8'h01, 32'h0000_0000, 1'b1);
    send(8'h8a, 8'h00, 32'h0000_0002, 1'b1);
    move(6'h02);
    get_event(32'h0000_0002);
    @(posedge clk_sys);
    #1;
    n = seen_count;
    move(6'h02);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(seen_count, n);
    // A request type other than once or always must arm nothing.
    send(8'h8a, 8'h02, 32'h0000_0001, 1'b1);
    @(posedge clk_sys);
    #1;
    n = seen_count;
    move(6'h01);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(seen_count, n);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short well past the hundred or so cycles the scenarios need.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_direct();
    t_vectors();
    t_event();
    wrap_up();
  end
endmodule
